// File: adc_port_pkg.sv
// Shared constants, states and carriers of the serial converter control port.
// Assumes one 100 MHz clock; all pins arrive synchronous to it.
package adc_port_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int RES_W = 12;
  localparam int CFG_W = 4;
  localparam int CNT_W = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [CNT_W-1:0] CFG_LAST = 4'h3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  // ----------------------------------------------------------------
  // Transfer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_SEARCH  = 3'h1,
    ST_CONFIG  = 3'h2,
    ST_NULL    = 3'h3,
    ST_MSB     = 3'h4,
    ST_LSB     = 3'h5,
    ST_FILL    = 3'h6,
    ST_PD_ONES = 3'h7
  } state_e;

  // ----------------------------------------------------------------
  // Configuration word, first received bit in the top field
  // ----------------------------------------------------------------
  typedef struct packed {
    logic single_ended_sel;
    logic polarity;
    logic msb_first_flag;
    logic power_keep_n;
  } cfg_s;

  localparam cfg_s CFG_RESET = 4'h0;

  // Multiplexer steering: positive input and negative reference
  localparam logic [1:0] NEG_GND = 2'h0;
  localparam logic [1:0] NEG_A = 2'h1;
  localparam logic [1:0] NEG_B = 2'h2;

  typedef struct packed {
    logic pos_is_b;
    logic [1:0] neg_sel;
  } mux_s;

endpackage

// File: sar_step.sv
// Successive-approximation register: one bit resolved per step pulse.
// Assumes an external comparator answering trial code against held input.
`timescale 1ns/1ns
`default_nettype none

module sar_step #(
  parameter int W = 12
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_step,
  input wire logic i_cmp,
  output logic [W-1:0] o_trial,
  output logic [W-1:0] o_result,
  output logic o_done
);

  if (W < 2) begin : bad_width
    $error("sar_step needs at least two bits");
  end

  logic [W-1:0] mask;
  logic [W-1:0] trial;
  logic [W-1:0] result;
  wire [W-1:0] top_mask = {1'b1, {(W-1){1'b0}}};
  wire [W-1:0] kept = result | (i_cmp ? mask : '0);
  wire [W-1:0] next_mask = mask >> 1;
  wire busy = |mask;

  // ----------------------------------------------------------------
  // Binary search, straight binary code with zero at ground
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mask <= '0;
      trial <= '0;
      result <= '0;
    end else if (i_start) begin
      mask <= top_mask;
      trial <= top_mask;
      result <= '0;
    end else if (i_step && busy) begin
      mask <= next_mask;
      result <= kept;
      trial <= kept | next_mask;
    end
  end

  assign o_trial = trial;
  assign o_result = result;
  assign o_done = ~busy;

endmodule

`default_nettype wire

// File: serial_adc_control_port.sv
// Control and serial-interface logic of a two-channel 12-bit converter.
// Assumes chip select, shift clock and data in are synchronous to I_CLK and
// that an external comparator reports analog input >= O_TRIAL on I_CMP.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Launch on falling, sample on rising.
// - Configuration in first, result out after.
// - Select falling edge begins a transfer.
// - First sampled one is start bit.
// - Four config bits follow, then conversion.
// - Ignore input until next select cycle.
// - Selector and polarity choose input pair.
// - One null bit, then result MSB first.
// - Result is 12-bit straight unipolar code.
// - MSB-first flag set: zeros after result.
// - Flag clear: LSB-first copy follows.
// - Power-keep zero selects power-down.
// - Power-down sends twelve ones, then zeros.
// - Power-down ends at next select cycle.
// - Select high resets the interface logic.
// - Device drives shared line from fifth fall.
// - Select high keeps output high impedance.
module serial_adc_control_port #(
  parameter int RES_W = adc_port_pkg::RES_W
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_CS_N,
  input wire logic I_SCLK,
  input wire logic I_DIN,
  input wire logic I_CMP,
  output logic O_DOUT,
  output logic O_DOUT_OE,
  output logic [RES_W-1:0] O_TRIAL,
  output adc_port_pkg::mux_s O_MUX,
  output logic O_HOLD,
  output logic O_POWER_DOWN,
  output logic [RES_W-1:0] O_RESULT
);

  if (RES_W < 2 || RES_W > (1 << adc_port_pkg::CNT_W)) begin : bad_res_w
    $error("RES_W out of range for the bit counter");
  end

  localparam logic [adc_port_pkg::CNT_W-1:0] RES_LAST =
    adc_port_pkg::CNT_W'(RES_W - 1);

  // ----------------------------------------------------------------
  // Shift clock edges
  // ----------------------------------------------------------------
  logic sclk_q;
  adc_port_pkg::state_e state;
  logic [adc_port_pkg::CNT_W-1:0] cnt;
  logic [adc_port_pkg::CFG_W-2:0] cfg_sh;
  adc_port_pkg::cfg_s cfg;
  logic dout;
  logic oe;
  logic hold;
  logic power_down;
  logic [RES_W-1:0] result;
  logic sar_done;

  // edge detect on the shift clock
  wire rise = I_SCLK & ~sclk_q;
  wire fall = ~I_SCLK & sclk_q;
  wire cs_low = ~I_CS_N;
  wire cfg_last = (cnt == adc_port_pkg::CFG_LAST);
  wire res_last = (cnt == RES_LAST);
  // first config bit lands in the top field
  wire adc_port_pkg::cfg_s cfg_word = {cfg_sh, I_DIN};
  wire cfg_done = (state == adc_port_pkg::ST_CONFIG) & rise & cfg_last & cs_low;
  wire sar_step_en = (state == adc_port_pkg::ST_MSB) & fall & cs_low;
  wire lsb_bit = result[cnt];
  // power-down capture leaves the converter and last code alone
  wire conv_start = cfg_done & cfg_word.power_keep_n;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= I_SCLK;
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state <= adc_port_pkg::ST_IDLE;
      cnt <= adc_port_pkg::CNT_ZERO;
      cfg_sh <= '0;
      dout <= 1'b0;
      oe <= 1'b0;
    end else if (I_CS_N) begin
      // select high returns to a fresh start-bit search
      state <= adc_port_pkg::ST_IDLE;
      cnt <= adc_port_pkg::CNT_ZERO;
      oe <= 1'b0;
    end else begin
      case (state)
        adc_port_pkg::ST_IDLE: begin
          // select low opens the start-bit search
          state <= adc_port_pkg::ST_SEARCH;
        end
        adc_port_pkg::ST_SEARCH: begin
          if (rise && I_DIN) begin
            state <= adc_port_pkg::ST_CONFIG;
            cnt <= adc_port_pkg::CNT_ZERO;
          end
        end
        adc_port_pkg::ST_CONFIG: begin
          // four configuration bits on rising edges
          if (rise) begin
            cfg_sh <= cfg_word[adc_port_pkg::CFG_W-2:0];
            cnt <= cnt + adc_port_pkg::CNT_ONE;
            if (cfg_last) begin
              state <= adc_port_pkg::ST_NULL;
            end
          end
        end
        adc_port_pkg::ST_NULL: begin
          // take the shared line on the next falling edge
          if (fall) begin
            dout <= 1'b0;
            oe <= 1'b1;
            cnt <= adc_port_pkg::CNT_ZERO;
            state <= cfg.power_keep_n ? adc_port_pkg::ST_MSB : adc_port_pkg::ST_PD_ONES;
          end
        end
        adc_port_pkg::ST_MSB: begin
          // each bit leaves as the comparator decides it
          if (fall) begin
            dout <= I_CMP;
            cnt <= cnt + adc_port_pkg::CNT_ONE;
            if (res_last) begin
              cnt <= adc_port_pkg::CNT_ZERO;
              // order flag decides between fill and LSB-first copy
              state <= cfg.msb_first_flag ? adc_port_pkg::ST_FILL : adc_port_pkg::ST_LSB;
            end
          end
        end
        adc_port_pkg::ST_LSB: begin
          // replay the stored code from bit zero up
          if (fall) begin
            dout <= lsb_bit;
            cnt <= cnt + adc_port_pkg::CNT_ONE;
            if (res_last) begin
              state <= adc_port_pkg::ST_FILL;
            end
          end
        end
        adc_port_pkg::ST_PD_ONES: begin
          // a word of ones before the zero fill
          if (fall) begin
            dout <= 1'b1;
            cnt <= cnt + adc_port_pkg::CNT_ONE;
            if (res_last) begin
              state <= adc_port_pkg::ST_FILL;
            end
          end
        end
        adc_port_pkg::ST_FILL: begin
          // zeros for as long as the host keeps clocking
          if (fall) begin
            dout <= 1'b0;
          end
        end
        default: begin
          state <= adc_port_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration, hold and power state
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      cfg <= adc_port_pkg::CFG_RESET;
      hold <= 1'b0;
      power_down <= 1'b0;
    end else if (I_CS_N) begin
      hold <= 1'b0;
    end else if (state == adc_port_pkg::ST_IDLE) begin
      // a new select cycle wakes the converter at once
      power_down <= 1'b0;
    end else if (cfg_done) begin
      // the word is taken once; later input is never read
      cfg <= cfg_word;
      hold <= cfg_word.power_keep_n;
      power_down <= ~cfg_word.power_keep_n;
    end
  end

  wire neg_diff = cfg.polarity ? 1'b0 : 1'b1;
  assign O_MUX.pos_is_b = cfg.polarity;
  assign O_MUX.neg_sel = cfg.single_ended_sel ? adc_port_pkg::NEG_GND :
                         (neg_diff ? adc_port_pkg::NEG_B : adc_port_pkg::NEG_A);

  // straight binary search gives the unipolar code
  sar_step #(
    .W(RES_W)
  ) u_sar (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_start(conv_start),
    .i_step(sar_step_en),
    .i_cmp(I_CMP),
    .o_trial(O_TRIAL),
    .o_result(result),
    .o_done(sar_done)
  );

  // driver only after the input phase and while selected
  assign O_DOUT_OE = oe & cs_low;
  assign O_DOUT = dout;
  assign O_HOLD = hold & ~sar_done;
  assign O_POWER_DOWN = power_down;
  assign O_RESULT = result;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  a_start_found: assert property (
    (state == adc_port_pkg::ST_SEARCH && rise && I_DIN && cs_low)
    |=> state == adc_port_pkg::ST_CONFIG) else $error("start bit missed");
  a_zero_dropped: assert property (
    (state == adc_port_pkg::ST_SEARCH && rise && !I_DIN && cs_low)
    |=> state == adc_port_pkg::ST_SEARCH) else $error("leading zero taken");
  a_cfg_capture: assert property (
    cfg_done |=> (state == adc_port_pkg::ST_NULL && cfg == $past(cfg_word)))
    else $error("config word not captured");
  a_cfg_frozen: assert property (
    (state > adc_port_pkg::ST_CONFIG && cs_low) |=> $stable(cfg))
    else $error("config changed after capture");
  a_null_bit: assert property (
    (state == adc_port_pkg::ST_NULL && fall && cs_low) |=> (!O_DOUT && oe))
    else $error("null bit wrong");
  a_msb_bit: assert property (
    sar_step_en |=> O_DOUT == $past(I_CMP)) else $error("result bit wrong");
  a_lsb_copy: assert property (
    (state == adc_port_pkg::ST_LSB && fall && cs_low) |=> O_DOUT == $past(lsb_bit))
    else $error("lsb-first bit wrong");
  a_fill_zero: assert property (
    (state == adc_port_pkg::ST_FILL && fall && cs_low) |=> !O_DOUT)
    else $error("fill not zero");
  a_pd_ones: assert property (
    (state == adc_port_pkg::ST_NULL && fall && cs_low && !cfg.power_keep_n)
    |=> (state == adc_port_pkg::ST_PD_ONES && O_POWER_DOWN))
    else $error("power-down ones missing");
  a_pd_wake: assert property (
    (state == adc_port_pkg::ST_IDLE && cs_low) |=> !O_POWER_DOWN)
    else $error("power-down not cleared");
  a_cs_reset: assert property (
    I_CS_N |=> (state == adc_port_pkg::ST_IDLE && !oe)) else $error("select high no reset");
  a_hiz_idle: assert property (
    I_CS_N |-> !O_DOUT_OE) else $error("driving while deselected");
  a_mux_single: assert property (
    cfg.single_ended_sel |-> O_MUX.neg_sel == adc_port_pkg::NEG_GND)
    else $error("single-ended not against ground");

  c_msb_only: cover property (state == adc_port_pkg::ST_MSB ##1 state == adc_port_pkg::ST_FILL);
  c_lsb_copy: cover property (state == adc_port_pkg::ST_LSB ##1 state == adc_port_pkg::ST_FILL);
  c_power_down: cover property (
    state == adc_port_pkg::ST_PD_ONES ##1 state == adc_port_pkg::ST_FILL);

endmodule

`default_nettype wire

// File: afe_model.sv
// Analog front end stand-in: multiplexer, sample-and-hold and comparator.
// Assumes input levels are ideal codes and the port steers the multiplexer.
`timescale 1ns/1ns
`default_nettype none

module afe_model (
  input wire logic i_clk,
  input wire logic i_hold,
  input wire adc_port_pkg::mux_s i_mux,
  input wire logic [adc_port_pkg::RES_W-1:0] i_trial,
  input wire logic [adc_port_pkg::RES_W-1:0] i_level_a,
  input wire logic [adc_port_pkg::RES_W-1:0] i_level_b,
  output logic o_cmp
);
  logic hold_q = 1'b0;
  logic [adc_port_pkg::RES_W-1:0] held = '0;
  wire [adc_port_pkg::RES_W-1:0] pos = i_mux.pos_is_b ? i_level_b : i_level_a;
  wire [adc_port_pkg::RES_W-1:0] neg = (i_mux.neg_sel == adc_port_pkg::NEG_A) ? i_level_a :
    (i_mux.neg_sel == adc_port_pkg::NEG_B) ? i_level_b : '0;
  // unipolar clipping
  // A negative difference reads as code zero, never wraps
  wire [adc_port_pkg::RES_W-1:0] diff = (pos > neg) ? pos - neg : '0;

  always @(posedge i_clk) begin
    hold_q <= i_hold;
    if (i_hold && !hold_q) begin
      held <= diff;
    end
  end

  assign o_cmp = (held >= i_trial);
endmodule

`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the serial converter control port.
// Assumes a host that shifts on a slow shift clock, three- or four-wire.
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); end end

module tb_top;
  logic clk = 1'b0;
  logic rst_n, cs_n, sclk, host_d, host_oe, three, cmp;
  logic dout, dout_oe, hold, pdn;
  logic [11:0] trial, result, lvl_a, lvl_b, k;
  logic [28:0] got;
  adc_port_pkg::mux_s mux;
  adc_port_pkg::cfg_s c;
  int err_total = 0;
  int n_tests = 0;
  // Pull-up on the shared data wire when nobody drives it
  wire data_w = dout_oe ? dout : (host_oe ? host_d : 1'b1);
  wire din = three ? data_w : host_d;

  always #5 clk = ~clk;

  serial_adc_control_port DUT (.I_CLK(clk), .I_RST_N(rst_n), .I_CS_N(cs_n), .I_SCLK(sclk),
    .I_DIN(din), .I_CMP(cmp), .O_DOUT(dout), .O_DOUT_OE(dout_oe), .O_TRIAL(trial),
    .O_MUX(mux), .O_HOLD(hold), .O_POWER_DOWN(pdn), .O_RESULT(result));

  afe_model afe (.i_clk(clk), .i_hold(hold), .i_mux(mux), .i_trial(trial),
    .i_level_a(lvl_a), .i_level_b(lvl_b), .o_cmp(cmp));

  // ----------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------
  function automatic logic [11:0] exp_code(adc_port_pkg::cfg_s f);
    logic [11:0] p;
    logic [11:0] n;
    p = f.polarity ? lvl_b : lvl_a;
    n = f.single_ended_sel ? 12'h000 : (f.polarity ? lvl_a : lvl_b);
    return (p > n) ? p - n : 12'h000;
  endfunction

  function automatic logic [28:0] exp_stream(adc_port_pkg::cfg_s f, logic [11:0] v);
    logic [11:0] r;
    for (int i = 0; i < 12; i++) begin
      r[i] = v[11-i];
    end
    if (!f.power_keep_n) begin
      return {1'b0, 12'hFFF, 16'h0000};
    end
    return {1'b0, v, f.msb_first_flag ? 12'h000 : r, 4'h0};
  endfunction

  function automatic adc_port_pkg::mux_s exp_mux(adc_port_pkg::cfg_s f);
    adc_port_pkg::mux_s m;
    m.pos_is_b = f.polarity;
    m.neg_sel = f.single_ended_sel ? adc_port_pkg::NEG_GND :
      (f.polarity ? adc_port_pkg::NEG_A : adc_port_pkg::NEG_B);
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Host side of the serial exchange
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One shift clock: launch on the fall, sample just before the rise
  task automatic sclk_bit(input logic d, output logic q);
    host_d = d;
    sclk = 1'b0;
    step(3);
    q = data_w;
    sclk = 1'b1;
    step(2);
  endtask

  task automatic xfer(input int nz, input adc_port_pkg::cfg_s f, input int nb, input logic tw,
                      output logic [28:0] g);
    logic q;
    g = '0;
    three = tw;
    host_oe = 1'b1;
    cs_n = 1'b0;
    step(3);
    `CHK(pdn, 1'b0)
    for (int i = 0; i < nz; i++) begin
      sclk_bit(1'b0, q);
    end
    sclk_bit(1'b1, q);
    for (int i = 3; i >= 0; i--) begin
      sclk_bit(f[i], q);
    end
    host_oe = 1'b0;
    `CHK(dout_oe, 1'b0)
    `CHK(mux, exp_mux(f))
    `CHK(pdn, ~f.power_keep_n)
    `CHK(hold, f.power_keep_n)
    // Four-wire runs toggle the input to show it is no longer heard
    for (int i = 0; i < nb; i++) begin
      sclk_bit(~tw & i[0], q);
      `CHK(dout_oe, 1'b1)
      g = {g[27:0], q};
    end
    // Shift clock parks low with the select rise, so that fall is never heard
    cs_n = 1'b1;
    sclk = 1'b0;
    #1;
    `CHK(dout_oe, 1'b0)
    step(3);
  endtask

  task automatic finish_test;
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    cs_n = 1'b1;
    sclk = 1'b0;
    host_d = 1'b0;
    host_oe = 1'b0;
    three = 1'b0;
    lvl_a = 12'h5A3;
    lvl_b = 12'hC3E;
    step(10);
    rst_n = 1'b1;
    step(2);
    `CHK(dout_oe, 1'b0)
    for (int s = 0; s < 2; s++) begin
      if (s == 1) begin
        lvl_a = 12'hFFF;
        lvl_b = 12'h000;
      end
      for (int i = 0; i < 4; i++) begin
        c = {~i[1], i[0], ~i[0] ^ s[0], 1'b1};
        xfer(i, c, 29, i[0], got);
        k = exp_code(c);
        `CHK(got, exp_stream(c, k))
        `CHK(result, k)
        `CHK(trial, k)
      end
    end
    c = 4'hA;
    xfer(2, c, 29, 1'b1, got);
    `CHK(got, exp_stream(c, 12'h000))
    c = 4'hB;
    xfer(0, c, 29, 1'b0, got);
    `CHK(got, exp_stream(c, exp_code(c)))
    // Byte-wide host: six leading zeros put the code in bytes two and three
    lvl_a = 12'h5A3;
    xfer(6, c, 13, 1'b0, got);
    `CHK(got[11:8], 4'h5)
    `CHK(got[7:0], 8'hA3)
    // Cut a conversion short; the next one must start clean
    c = 4'h5;
    xfer(0, c, 6, 1'b0, got);
    c = 4'h9;
    xfer(1, c, 29, 1'b1, got);
    `CHK(got, exp_stream(c, exp_code(c)))
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule

`default_nettype wire
